/* hdl/mlc_top.sv */
// low-carrier select, polarity and carrier-switch hold-off with an APB control register
// assumes carrier sources and capture mode flags are asynchronous levels;
// mod_data comes from logic on pclk
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "mlc_consts.svh"
module mlc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// index equals select code; bits 0 and 9 are not read
	input wire logic [15:0] carrier_src,
	// bit 0 capture unit a, bit 1 capture unit b in PWM output mode
	input wire logic [1:0] capture_pwm_mode,
	input wire logic mod_data,
	output logic low_carrier_out,
	output logic use_high_carrier
);
	logic [17:0] sync_vec;
	logic [15:0] src_s;
	logic [1:0] pwm_s;

	mlc_sync #(.W(18)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({capture_pwm_mode, carrier_src}),
		.sync_out(sync_vec)
	);

	assign src_s = sync_vec[15:0];
	assign pwm_s = sync_vec[17:16];

	// register bus
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic hit;
	logic access;

	assign hit = (paddr == `MLC_CTRL_OFF);
	assign access = psel && penable && !pready_q;

	always_comb begin
		ctrl_d = ctrl_q;
		prdata_d = 32'h0000_0000;
		pready_d = access;
		pslverr_d = access && !hit;
		if (access && hit && pwrite) begin
			ctrl_d = pwdata[7:0] & `MLC_CTRL_WMASK; // R7
		end
		if (access && hit && !pwrite) begin
			prdata_d = {24'h00_0000, ctrl_q & `MLC_CTRL_WMASK}; // R7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `MLC_CTRL_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	logic inv;
	logic sync_en;
	logic [3:0] sel;
	assign inv = ctrl_q[`MLC_INV_BIT];
	assign sync_en = ctrl_q[`MLC_SYNC_BIT];
	assign sel = ctrl_q[`MLC_SEL_MSB:`MLC_SEL_LSB];

	// carrier selection
	logic carrier_raw;
	always_comb begin
		carrier_raw = src_s[sel]; // R4
		case (sel)
			`MLC_SEL_GND: begin
				carrier_raw = 1'b0; // R4
			end
			`MLC_SEL_RSVD: begin
				carrier_raw = 1'b0; // R5
			end
			`MLC_SEL_CAP_A: begin
				carrier_raw = src_s[sel] && pwm_s[0]; // R6
			end
			`MLC_SEL_CAP_B: begin
				carrier_raw = src_s[sel] && pwm_s[1]; // R6
			end
			default: begin
				carrier_raw = src_s[sel];
			end
		endcase
	end

	// polarity and edge history
	logic carrier_q;
	logic carrier_d;
	logic carrier_prev_q;
	logic fall;

	always_comb begin
		carrier_d = carrier_raw ^ inv; // R1
	end

	assign fall = carrier_prev_q && !carrier_q;

	// carrier switch state
	mlc_pkg::mlc_state_type state_q;
	mlc_pkg::mlc_state_type state_d;
	logic use_high_q;
	logic use_high_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			mlc_pkg::MLC_ST_LOW: begin
				if (mod_data && !sync_en) begin
					state_d = mlc_pkg::MLC_ST_HIGH; // R3
				end else if (mod_data) begin
					state_d = mlc_pkg::MLC_ST_WAIT; // R2
				end
			end
			mlc_pkg::MLC_ST_WAIT: begin
				if (!mod_data) begin
					state_d = mlc_pkg::MLC_ST_LOW;
				end else if (fall || !sync_en) begin
					state_d = mlc_pkg::MLC_ST_HIGH; // R2
				end
			end
			mlc_pkg::MLC_ST_HIGH: begin
				if (!mod_data) begin
					state_d = mlc_pkg::MLC_ST_LOW;
				end
			end
			default: begin
				state_d = mlc_pkg::MLC_ST_LOW;
			end
		endcase
		use_high_d = (state_d == mlc_pkg::MLC_ST_HIGH);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carrier_q <= 1'b0;
			carrier_prev_q <= 1'b0;
			state_q <= mlc_pkg::MLC_ST_LOW;
			use_high_q <= 1'b0;
		end else begin
			carrier_q <= carrier_d;
			carrier_prev_q <= carrier_q;
			state_q <= state_d;
			use_high_q <= use_high_d;
		end
	end

	assign low_carrier_out = carrier_q;
	assign use_high_carrier = use_high_q;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	polarity_out_a: assert property ( // R1
		carrier_q == ($past(carrier_raw) ^ $past(inv)))
		else $error("low carrier polarity wrong");

	sync_holdoff_a: assert property ( // R2
		$rose(use_high_q) && $past(sync_en) && $past(state_q) == mlc_pkg::MLC_ST_WAIT
		|-> $past(fall))
		else $error("switch to high carrier without falling edge");

	sync_entry_a: assert property ( // R2
		state_q == mlc_pkg::MLC_ST_LOW && mod_data && sync_en |=> !use_high_q)
		else $error("synchronised switch did not wait");

	nosync_switch_a: assert property ( // R3
		state_q == mlc_pkg::MLC_ST_LOW && mod_data && !sync_en |=> use_high_q)
		else $error("unsynchronised switch delayed");

	select_map_a: assert property ( // R4
		sel != `MLC_SEL_GND && sel != `MLC_SEL_RSVD && sel != `MLC_SEL_CAP_A
		&& sel != `MLC_SEL_CAP_B && $stable(sel) && $stable(inv)
		|=> low_carrier_out == ($past(src_s[sel]) ^ $past(inv)))
		else $error("select code routed wrong source");

	reserved_off_a: assert property ( // R5
		(sel == `MLC_SEL_RSVD || sel == `MLC_SEL_GND) ##1 $stable(ctrl_q)
		|-> low_carrier_out == inv)
		else $error("reserved or ground code passed a carrier");

	capture_gate_a: assert property ( // R6
		(sel == `MLC_SEL_CAP_A && !pwm_s[0]) || (sel == `MLC_SEL_CAP_B && !pwm_s[1])
		|-> !carrier_raw)
		else $error("capture output passed outside PWM mode");

	reserved_bits_a: assert property ( // R7
		pready_q |-> !prdata_q[7] && !prdata_q[4] && !ctrl_q[7] && !ctrl_q[4])
		else $error("unimplemented bits not zero");

	apb_answer_a: assert property (
		psel && penable && !pready_q |=> pready_q ##1 !pready_q)
		else $error("apb answer not one cycle");

	sync_switch_c: cover property (
		state_q == mlc_pkg::MLC_ST_WAIT && sync_en ##[1:20] $rose(use_high_q));
	nosync_switch_c: cover property (!sync_en && mod_data ##1 $rose(use_high_q));
	capture_sel_c: cover property (sel == `MLC_SEL_CAP_A && pwm_s[0] && carrier_raw);
	bad_addr_c: cover property (pslverr_q);
endmodule

/* hdl/mlc_consts.svh */
// constants for the modulator low-carrier control block
// assumes an APB slave with 32-bit data; only the low byte is used
//
// Behaviour
// R1 - invert bit set inverts the selected low carrier, clear passes it unchanged
// R2 - sync enable set: switch to high carrier waits for low carrier falling edge
// R3 - sync enable clear: switch away from low carrier happens at once
// R4 - four-bit select picks logic cells, oscillators, clock, pulse gens, ref clock, ground
// R5 - reserved select code connects no carrier source
// R6 - capture unit codes pass their output only while in PWM output mode
// R7 - bits 7 and 4 ignore writes, read zero; other bits keep value
`ifndef MLC_CONSTS_SVH
`define MLC_CONSTS_SVH

`define MLC_CTRL_OFF 12'h000
`define MLC_INV_BIT 6
`define MLC_SYNC_BIT 5
`define MLC_SEL_MSB 3
`define MLC_SEL_LSB 0
`define MLC_CTRL_RST 8'h00
`define MLC_CTRL_WMASK 8'h6F
`define MLC_SEL_GND 4'h0
`define MLC_SEL_RSVD 4'h9
`define MLC_SEL_CAP_A 4'h4
`define MLC_SEL_CAP_B 4'h5
`define MLC_SYNC_STAGES 2

`endif

/* hdl/mlc_pkg.sv */
// types for the modulator low-carrier control block
// assumes nothing beyond the constants header
package mlc_pkg;
	typedef enum logic [1:0] {
		MLC_ST_LOW = 2'b00,
		MLC_ST_WAIT = 2'b01,
		MLC_ST_HIGH = 2'b11
	} mlc_state_type;
endpackage

/* hdl/mlc_sync.sv */
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level or a carrier below half of pclk
`timescale 1ns/1ps
module mlc_sync #(
	parameter int W = 18
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
				end
			end
			assign sync_out[i] = sync_q;
		end
	endgenerate
endmodule

/* tb/mlc_src_model.sv */
// carrier sources: static pattern or free-running divided carriers
// assumes run and pat are driven by the bench after a rising edge
`timescale 1ns/1ps
module mlc_src_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [15:0] pat,
	output logic [15:0] carrier_src
);
	logic [3:0] div_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) div_q <= 4'h0;
		else div_q <= div_q + 4'h1;
	end
	// carriers stay below half of pclk
	always_comb begin
		for (int i = 0; i < 16; i++) carrier_src[i] = run ? div_q[1 + i % 3] : pat[i];
	end
endmodule

/* tb/modulator_low_carrier_select_bench.sv */
// self-checking bench for the low-carrier control block
// assumes mlc_top answers on APB and carriers come from mlc_src_model
`timescale 1ns/1ps
module modulator_low_carrier_select_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mod_data = 0, run = 0;
	logic lco, uhc, pready, pslverr, er, v, h1, h2;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'hBFD3;
	logic [15:0] pat = 16'h0, src;
	logic [1:0] cap = 2'h0;
	int err_count = 0, tests_run = 0, cyc = 0, mdl_ctrl = 0;
	initial forever #20 pclk = ~pclk;
	mlc_src_model u_mlc_src_model(.pclk(pclk), .presetn(presetn), .run(run), .pat(pat),
		.carrier_src(src));
	mlc_top u_mlc_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .carrier_src(src), .capture_pwm_mode(cap), .mod_data(mod_data),
		.low_carrier_out(lco), .use_high_carrier(uhc));
	function logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready ends this wait; failing that, only the bench timeout does
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		// model register: only bits 6, 5 and 3:0 take writes
		if (w && a == 12'h000) mdl_ctrl = d[7:0] & 8'h6F;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			test_done;
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			lf = nx(lf);
			apb(1'b1, 12'h000, lf);
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, mdl_ctrl);
			chk({31'h0, er}, 32'h0);
		end
		apb(1'b1, 12'h004, 32'hFF);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, mdl_ctrl);
		$display("register test done");
		for (int c = 0; c < 32; c++) begin
			lf = nx(lf);
			@(posedge pclk);
			pat <= lf[15:0];
			cap <= lf[17:16];
			apb(1'b1, 12'h000, {25'h0, c[4], 2'b00, c[3:0]});
			repeat (4) @(posedge pclk);
			#1;
			v = pat[c[3:0]] & (c[3:0] != 0) & (c[3:0] != 9);
			v = v & !(c[3:0] == 4 && !cap[0]) & !(c[3:0] == 5 && !cap[1]);
			chk({31'h0, lco}, {31'h0, v ^ c[4]});
		end
		$display("select test done");
		apb(1'b1, 12'h000, 32'h0F);
		pat <= 16'hFFFF;
		repeat (4) @(posedge pclk);
		mod_data <= 1'b1;
		@(posedge pclk);
		#1;
		chk({31'h0, uhc}, 32'h1);
		@(posedge pclk);
		mod_data <= 1'b0;
		apb(1'b1, 12'h000, 32'h2F);
		run <= 1'b1;
		repeat (4) @(posedge pclk);
		mod_data <= 1'b1;
		// history starts with the real carrier level, not a guess
		#1;
		h1 = lco;
		h2 = 1'b0;
		for (int n = 0; n < 40; n++) begin
			@(posedge pclk);
			#1;
			if (uhc === 1'b1) break;
			h2 = h1;
			h1 = lco;
		end
		chk({29'h0, uhc, h2, h1}, 32'h6);
		$display("switch test done");
		test_done;
	end
endmodule
